//--- uia_pkg.sv
// Shared constants, modes and carriers for the user input assertion block
package uia_pkg;

	localparam int UIA_AW = 8;
	localparam int UIA_DW = 32;

	// Register byte offsets
	localparam logic [7:0] UIA_OFF_CTRL = 8'h00;
	localparam logic [7:0] UIA_OFF_VIRT = 8'h04;
	localparam logic [7:0] UIA_OFF_LABEL = 8'h08;
	localparam logic [7:0] UIA_OFF_STATUS = 8'h0c;
	localparam logic [7:0] UIA_OFF_EVCNT = 8'h10;
	localparam logic [7:0] UIA_OFF_EVREC = 8'h14;

	// Field positions
	localparam int UIA_CTRL_MODE_LSB = 0;
	localparam int UIA_CTRL_MODE_W = 5;
	localparam int UIA_CTRL_LSEL_BIT = 8;
	localparam int UIA_VIRT_ON_BIT = 0;
	localparam int UIA_LABEL_W = 16;
	localparam int UIA_ST_ASSERT_BIT = 0;
	localparam int UIA_ST_CONT_BIT = 1;
	localparam int UIA_ST_VIRT_BIT = 2;
	localparam int UIA_EVCNT_W = 16;
	localparam int UIA_EVREC_CONT_BIT = 8;
	localparam int UIA_EVREC_VIRT_BIT = 9;
	localparam int UIA_EVREC_NEW_BIT = 31;

	// Reset values
	localparam logic UIA_RST_LSEL = 1'b0;
	localparam logic UIA_RST_VIRT = 1'b0;
	localparam logic [15:0] UIA_RST_LABEL = 16'h0000;
	localparam logic [15:0] UIA_RST_EVCNT = 16'h0000;
	// Default label code for the diagnostic message; the value is arbitrary
	localparam logic [15:0] UIA_DEFAULT_LABEL = 16'h00a1;

	typedef enum logic [4:0] {
		UIA_M_DISABLED = 5'h00,
		UIA_M_CLOSED = 5'h01,
		UIA_M_OPEN = 5'h02,
		UIA_M_VON = 5'h03,
		UIA_M_VOFF = 5'h04,
		UIA_M_CL_AND_VON = 5'h05,
		UIA_M_CL_AND_VOFF = 5'h06,
		UIA_M_OP_AND_VON = 5'h07,
		UIA_M_OP_AND_VOFF = 5'h08,
		UIA_M_CL_OR_VON = 5'h09,
		UIA_M_CL_OR_VOFF = 5'h0a,
		UIA_M_OP_OR_VON = 5'h0b,
		UIA_M_OP_OR_VOFF = 5'h0c,
		UIA_M_CL_X_VON = 5'h0d,
		UIA_M_CL_X_VOFF = 5'h0e,
		UIA_M_OP_X_VON = 5'h0f,
		UIA_M_OP_X_VOFF = 5'h10
	} uia_mode_t;

	localparam uia_mode_t UIA_RST_MODE = UIA_M_DISABLED;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} uia_bus_req_t;

	typedef struct packed {
		logic diag;
		logic led;
		logic relay;
	} uia_ind_t;

endpackage

//--- uia_sync.sv
// Two-stage synchroniser for the field contact level
module uia_sync (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sys_ce,
	input wire logic async_in,
	output logic sync_out
);
	import uia_pkg::*;

	logic meta_q;
	logic sync_q;

	// Only the second stage is visible outside
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (sys_ce) begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

//--- uia_combine.sv
// Level combination of contact and virtual operands per selected mode
module uia_combine (
	input uia_pkg::uia_mode_t mode,
	input wire logic closed,
	input wire logic von,
	output logic result
);
	import uia_pkg::*;

	logic opn;
	logic voff;

	assign opn = ~closed;
	assign voff = ~von;

	always_comb begin
		result = 1'b0;
		case (mode)
			UIA_M_CLOSED: result = closed; // [R14]
			UIA_M_OPEN: result = opn; // [R14]
			UIA_M_VON: result = von; // [R14]
			UIA_M_VOFF: result = voff; // [R14]
			UIA_M_CL_AND_VON: result = closed & von;
			UIA_M_CL_AND_VOFF: result = closed & voff;
			UIA_M_OP_AND_VON: result = opn & von;
			UIA_M_OP_AND_VOFF: result = opn & voff; // [R1]
			UIA_M_CL_OR_VON: result = closed | von; // [R2]
			UIA_M_CL_OR_VOFF: result = closed | voff; // [R3]
			UIA_M_OP_OR_VON: result = opn | von; // [R4]
			UIA_M_OP_OR_VOFF: result = opn | voff; // [R5]
			UIA_M_CL_X_VON: result = closed ^ von; // [R6]
			UIA_M_CL_X_VOFF: result = closed ^ voff; // [R7]
			UIA_M_OP_X_VON: result = opn ^ von; // [R8]
			UIA_M_OP_X_VOFF: result = opn ^ voff; // [R9]
			default: result = 1'b0;
		endcase
	end

endmodule

//--- uia_top.sv
// User input assertion logic: operands, combination, indicators, event record
//
// Contract
// R1: Open-and-virtual-off mode asserts only while contact open and virtual off together.
// R2: Closed-or-von mode asserts if contact closed or virtual on.
// R3: Closed-or-voff mode asserts if contact closed or virtual off.
// R4: Open-or-von mode asserts if contact open or virtual on.
// R5: Open-or-voff mode asserts if contact open or virtual off.
// R6: Closed-xor-von mode asserts when exactly one of closed, virtual on holds.
// R7: Closed-xor-voff mode asserts when exactly one of closed, virtual off holds.
// R8: Open-xor-von mode asserts when exactly one of open, virtual on holds.
// R9: Open-xor-voff mode asserts when exactly one of open, virtual off holds.
// R10: On assertion show message with default or user label, light LED, pull relay.
// R11: On assertion log an event recorder entry naming the invoked function.
// R12: When the condition drops, clear message, LED and relay.
// R13: While the condition holds, indicators stay active through operand changes.
// R14: Single-operand modes ignore the other operand entirely.
// R15: Evaluate each cycle on synchronised operands; pulse an event on each rise.
module uia_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sys_ce,
	input wire logic contact_in,
	input uia_pkg::uia_bus_req_t bus_req,
	output logic [31:0] rd_data_q,
	output uia_pkg::uia_ind_t ind_q,
	output logic [15:0] diag_label_q,
	output logic evt_q
);
	import uia_pkg::*;

	// Register state
	uia_mode_t mode_q;
	uia_mode_t mode_d;
	logic lsel_q;
	logic lsel_d;
	logic virt_q;
	logic virt_d;
	logic [15:0] label_q;
	logic [15:0] label_d;
	logic [15:0] evcnt_q;
	logic [15:0] evcnt_d;
	uia_mode_t rec_mode_q;
	uia_mode_t rec_mode_d;
	logic rec_cont_q;
	logic rec_cont_d;
	logic rec_virt_q;
	logic rec_virt_d;
	logic rec_new_q;
	logic rec_new_d;

	// Datapath
	logic cont_s;
	logic result_d;
	logic rise_d;
	uia_ind_t ind_d;
	logic [15:0] diag_label_d;
	logic [31:0] rd_mux;
	logic [31:0] rd_data_d;

	// Address decode
	logic hit_ctrl;
	logic hit_virt;
	logic hit_label;
	logic hit_status;
	logic hit_evcnt;
	logic hit_evrec;
	logic wr_ctrl;
	logic wr_virt;
	logic wr_label;
	logic wr_evcnt;
	logic wr_evrec;
	logic [4:0] wmode;
	logic wmode_ok;

	// Contact comes from a field pin, so it is synchronised before use
	uia_sync u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sys_ce(sys_ce),
		.async_in(contact_in),
		.sync_out(cont_s)
	); // [R15]

	uia_combine u_comb (
		.mode(mode_q),
		.closed(cont_s),
		.von(virt_q),
		.result(result_d)
	); // [R15]

	assign hit_ctrl = bus_req.addr == UIA_OFF_CTRL;
	assign hit_virt = bus_req.addr == UIA_OFF_VIRT;
	assign hit_label = bus_req.addr == UIA_OFF_LABEL;
	assign hit_status = bus_req.addr == UIA_OFF_STATUS;
	assign hit_evcnt = bus_req.addr == UIA_OFF_EVCNT;
	assign hit_evrec = bus_req.addr == UIA_OFF_EVREC;

	assign wr_ctrl = bus_req.wr & hit_ctrl;
	assign wr_virt = bus_req.wr & hit_virt;
	assign wr_label = bus_req.wr & hit_label;
	assign wr_evcnt = bus_req.wr & hit_evcnt;
	assign wr_evrec = bus_req.wr & hit_evrec;

	// Codes beyond the last mode fall back to disabled rather than alias
	assign wmode = bus_req.wdata[UIA_CTRL_MODE_LSB +: UIA_CTRL_MODE_W];
	assign wmode_ok = wmode <= UIA_M_OP_X_VOFF;
	assign mode_d = wr_ctrl ? (wmode_ok ? uia_mode_t'(wmode) : UIA_M_DISABLED) : mode_q;
	assign lsel_d = wr_ctrl ? bus_req.wdata[UIA_CTRL_LSEL_BIT] : lsel_q;
	assign virt_d = wr_virt ? bus_req.wdata[UIA_VIRT_ON_BIT] : virt_q;
	assign label_d = wr_label ? bus_req.wdata[UIA_LABEL_W-1:0] : label_q;

	// Indicators follow the level each cycle; the rise is the logged event
	assign rise_d = result_d & ~ind_q.diag; // [R11] [R15]
	assign ind_d.diag = result_d; // [R10] [R12] [R13]
	assign ind_d.led = result_d; // [R10] [R12]
	assign ind_d.relay = result_d; // [R10] [R12]
	assign diag_label_d = result_d ? (lsel_q ? label_q : UIA_DEFAULT_LABEL) : 16'h0000; // [R10]

	// Counter wraps; a clear in the same cycle as an event leaves one entry
	assign evcnt_d = rise_d ? (wr_evcnt ? 16'h0001 : evcnt_q + 16'h0001) :
		(wr_evcnt ? UIA_RST_EVCNT : evcnt_q); // [R11]

	// Record captures the function and operands at the rise; set beats clear
	assign rec_mode_d = rise_d ? mode_q : rec_mode_q; // [R11]
	assign rec_cont_d = rise_d ? cont_s : rec_cont_q;
	assign rec_virt_d = rise_d ? virt_q : rec_virt_q;
	assign rec_new_d = rise_d | (rec_new_q & ~wr_evrec); // [R11]

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux[UIA_CTRL_MODE_LSB +: UIA_CTRL_MODE_W] = mode_q;
			rd_mux[UIA_CTRL_LSEL_BIT] = lsel_q;
		end
		if (hit_virt) begin
			rd_mux[UIA_VIRT_ON_BIT] = virt_q;
		end
		if (hit_label) begin
			rd_mux[UIA_LABEL_W-1:0] = label_q;
		end
		if (hit_status) begin
			rd_mux[UIA_ST_ASSERT_BIT] = ind_q.diag;
			rd_mux[UIA_ST_CONT_BIT] = cont_s;
			rd_mux[UIA_ST_VIRT_BIT] = virt_q;
		end
		if (hit_evcnt) begin
			rd_mux[UIA_EVCNT_W-1:0] = evcnt_q;
		end
		if (hit_evrec) begin
			rd_mux[UIA_CTRL_MODE_LSB +: UIA_CTRL_MODE_W] = rec_mode_q;
			rd_mux[UIA_EVREC_CONT_BIT] = rec_cont_q;
			rd_mux[UIA_EVREC_VIRT_BIT] = rec_virt_q;
			rd_mux[UIA_EVREC_NEW_BIT] = rec_new_q;
		end
	end

	// Read data stands only in the cycle after the strobe
	assign rd_data_d = bus_req.rd ? rd_mux : 32'h0000_0000;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mode_q <= UIA_RST_MODE;
			lsel_q <= UIA_RST_LSEL;
			virt_q <= UIA_RST_VIRT;
			label_q <= UIA_RST_LABEL;
		end else if (sys_ce) begin
			mode_q <= mode_d;
			lsel_q <= lsel_d;
			virt_q <= virt_d;
			label_q <= label_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			evcnt_q <= UIA_RST_EVCNT;
			rec_mode_q <= UIA_M_DISABLED;
			rec_cont_q <= 1'b0;
			rec_virt_q <= 1'b0;
			rec_new_q <= 1'b0;
		end else if (sys_ce) begin
			evcnt_q <= evcnt_d;
			rec_mode_q <= rec_mode_d;
			rec_cont_q <= rec_cont_d;
			rec_virt_q <= rec_virt_d;
			rec_new_q <= rec_new_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ind_q <= '0;
			diag_label_q <= 16'h0000;
			evt_q <= 1'b0;
			rd_data_q <= 32'h0000_0000;
		end else if (sys_ce) begin
			ind_q <= ind_d;
			diag_label_q <= diag_label_d;
			evt_q <= rise_d;
			rd_data_q <= rd_data_d;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_open_and_voff: assert property (sys_ce && mode_q == UIA_M_OP_AND_VOFF |=> // [R1]
		ind_q.diag == (!$past(cont_s) && !$past(virt_q)))
		else $error("open-and-voff result wrong");

	a_cl_or_von: assert property (sys_ce && mode_q == UIA_M_CL_OR_VON |=> // [R2]
		ind_q.diag == ($past(cont_s) || $past(virt_q)))
		else $error("closed-or-von result wrong");

	a_cl_or_voff: assert property (sys_ce && mode_q == UIA_M_CL_OR_VOFF |=> // [R3]
		ind_q.diag == ($past(cont_s) || !$past(virt_q)))
		else $error("closed-or-voff result wrong");

	a_op_or_von: assert property (sys_ce && mode_q == UIA_M_OP_OR_VON |=> // [R4]
		ind_q.diag == (!$past(cont_s) || $past(virt_q)))
		else $error("open-or-von result wrong");

	a_op_or_voff: assert property (sys_ce && mode_q == UIA_M_OP_OR_VOFF |=> // [R5]
		ind_q.diag == (!$past(cont_s) || !$past(virt_q)))
		else $error("open-or-voff result wrong");

	a_cl_xor_von: assert property (sys_ce && mode_q == UIA_M_CL_X_VON |=> // [R6]
		ind_q.diag == ($past(cont_s) != $past(virt_q)))
		else $error("closed-xor-von result wrong");

	a_cl_xor_voff: assert property (sys_ce && mode_q == UIA_M_CL_X_VOFF |=> // [R7]
		ind_q.diag == ($past(cont_s) == $past(virt_q)))
		else $error("closed-xor-voff result wrong");

	a_op_xor_von: assert property (sys_ce && mode_q == UIA_M_OP_X_VON |=> // [R8]
		ind_q.diag == ($past(cont_s) == $past(virt_q)))
		else $error("open-xor-von result wrong");

	a_op_xor_voff: assert property (sys_ce && mode_q == UIA_M_OP_X_VOFF |=> // [R9]
		ind_q.diag == ($past(cont_s) != $past(virt_q)))
		else $error("open-xor-voff result wrong");

	a_ind_label_match: assert property (ind_q.diag |-> ind_q.led && ind_q.relay && // [R10]
		diag_label_q == (lsel_q ? label_q : UIA_DEFAULT_LABEL) || $changed(lsel_q) ||
		$changed(label_q))
		else $error("indicators or label disagree with message");

	a_event_logged: assert property (sys_ce && result_d && !ind_q.diag |=> // [R11]
		evt_q && ind_q.diag && rec_new_q && rec_mode_q == $past(mode_q))
		else $error("assertion rise not logged");

	a_drop_clears: assert property (sys_ce && !result_d |=> // [R12]
		!ind_q.diag && !ind_q.led && !ind_q.relay && diag_label_q == 16'h0000 && !evt_q)
		else $error("indicators not cleared on drop");

	a_hold_steady: assert property (sys_ce && result_d && ind_q.diag |=> // [R13]
		ind_q.diag && ind_q.led && ind_q.relay && !evt_q)
		else $error("indicators dropped or event repeated while held");

	a_single_cont: assert property (sys_ce && mode_q == UIA_M_CLOSED |=> // [R14]
		ind_q.diag == $past(cont_s))
		else $error("contact-only mode looked at virtual input");

	a_single_virt: assert property (sys_ce && mode_q == UIA_M_VOFF |=> // [R14]
		ind_q.diag == !$past(virt_q))
		else $error("virtual-only mode looked at contact");

	a_event_single: assert property (evt_q && sys_ce |=> !evt_q) // [R15]
		else $error("event pulse longer than one cycle");

	a_freeze_hold: assert property (!sys_ce |=> $stable(ind_q) && $stable(evcnt_q) && // [R15]
		$stable(mode_q))
		else $error("state moved with clock enable low");

	// Operand-only and disabled modes, the per-cycle level and the label it carries
	a_single_open: assert property (sys_ce && mode_q == UIA_M_OPEN |=> // [R14]
		ind_q.diag == !$past(cont_s))
		else $error("open-only mode looked at virtual input");

	a_single_von: assert property (sys_ce && mode_q == UIA_M_VON |=> // [R14]
		ind_q.diag == $past(virt_q))
		else $error("virtual-on mode looked at contact");

	a_idle_mode: assert property (sys_ce && mode_q == UIA_M_DISABLED |=> // [R12]
		!ind_q.diag)
		else $error("disabled mode raised the message");

	a_level_follow: assert property (sys_ce |=> ind_q.diag == $past(result_d)) // [R15]
		else $error("message level lags the combined result");

	a_label_track: assert property (sys_ce && result_d |=> // [R10]
		diag_label_q == ($past(lsel_q) ? $past(label_q) : UIA_DEFAULT_LABEL))
		else $error("message label is not the selected one");

	a_label_blank: assert property (!ind_q.diag |-> diag_label_q == 16'h0000) // [R12]
		else $error("label shown without a message");

	// Event pulse, counter and record; a rise beats a clear in the same cycle
	a_no_stray_evt: assert property (sys_ce && !(result_d && !ind_q.diag) |=> // [R15]
		!evt_q)
		else $error("event pulse without a rise");

	a_evcnt_step: assert property (sys_ce && rise_d && !wr_evcnt |=> // [R11]
		evcnt_q == $past(evcnt_q) + 16'h0001)
		else $error("event count did not advance on a rise");

	a_evcnt_idle: assert property (sys_ce && !rise_d && !wr_evcnt |=> // [R11]
		$stable(evcnt_q))
		else $error("event count moved without a rise");

	a_evcnt_clear: assert property (sys_ce && wr_evcnt && !rise_d |=> // [R11]
		evcnt_q == UIA_RST_EVCNT)
		else $error("event count not cleared by a write");

	a_evcnt_clash: assert property (sys_ce && wr_evcnt && rise_d |=> // [R11]
		evcnt_q == 16'h0001)
		else $error("clear and rise together did not leave one entry");

	a_rec_new_clear: assert property (sys_ce && wr_evrec && !rise_d |=> !rec_new_q) // [R11]
		else $error("record new flag not cleared by a write");

	a_rec_operands: assert property (sys_ce && rise_d |=> // [R11]
		rec_cont_q == $past(cont_s) && rec_virt_q == $past(virt_q))
		else $error("record operands not captured at the rise");

	a_rec_hold: assert property (sys_ce && !rise_d |=> // [R11]
		$stable(rec_mode_q) && $stable(rec_cont_q) && $stable(rec_virt_q))
		else $error("record changed without a rise");

	// Contact path and what software reads of it, of the message and of the event count
	a_sync_delay: assert property (sys_ce ##1 sys_ce |=> // [R15]
		cont_s == $past(contact_in, 2))
		else $error("contact did not pass exactly two stages");

	a_status_read: assert property (sys_ce && bus_req.rd && hit_status |=> // [R10]
		rd_data_q[UIA_ST_ASSERT_BIT] == $past(ind_q.diag))
		else $error("status read disagrees with the message");

	a_status_operands: assert property (sys_ce && bus_req.rd && hit_status |=> // [R15]
		rd_data_q[UIA_ST_CONT_BIT] == $past(cont_s) &&
		rd_data_q[UIA_ST_VIRT_BIT] == $past(virt_q))
		else $error("status read shows stale operands");

	a_evcnt_read: assert property (sys_ce && bus_req.rd && hit_evcnt |=> // [R11]
		rd_data_q[UIA_EVCNT_W-1:0] == $past(evcnt_q))
		else $error("event count read disagrees with the counter");

endmodule

//--- uia_field_model.sv
// Field contact seen by the relay: a level that moves off the clock grid
module uia_field_model (
	input wire logic sys_clk,
	input wire logic want_closed,
	output logic contact_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial contact_in = 1'b0;

	// Lands 7 ns after the edge so the synchroniser really sees an asynchronous level
	always @(posedge sys_clk) begin
		contact_in <= #7 want_closed;
	end
endmodule

//--- uia_top_tb.sv
// Self-checking bench for the user input assertion logic
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module uia_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import uia_pkg::*;

	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sys_ce = 1'b1;
	logic want_closed = 1'b0;
	logic contact_in;
	uia_bus_req_t bus_req = '0;
	logic [31:0] rd_data_q;
	uia_ind_t ind_q;
	logic [15:0] diag_label_q;
	logic evt_q;
	logic rd_d = 1'b0;
	logic peek = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] nxt;
	int failures = 0;
	int total_checks = 0;
	int rises = 0;
	int evt_seen = 0;
	logic [4:0] cur_m = 5'h0;
	logic cur_c = 1'b0;
	logic cur_v = 1'b0;
	logic cur_r = 1'b0;
	logic cur_s = 1'b0;
	logic [15:0] label = 16'h0;
	logic [31:0] evrec = 32'h0;

	always #12.5 sys_clk = ~sys_clk;

	uia_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(sys_ce), .contact_in(contact_in),
		.bus_req(bus_req), .rd_data_q(rd_data_q), .ind_q(ind_q), .diag_label_q(diag_label_q),
		.evt_q(evt_q));
	uia_field_model field (.sys_clk(sys_clk), .want_closed(want_closed), .contact_in(contact_in));

	// Reference combination, written from the mode list rather than the design
	function automatic logic f(input logic [4:0] m, input logic c, input logic v);
		case (m)
			5'h01: f = c;
			5'h02: f = !c;
			5'h03: f = v;
			5'h04: f = !v;
			5'h05: f = c & v;
			5'h06: f = c & !v;
			5'h07: f = !c & v;
			5'h08: f = !c & !v;
			5'h09: f = c | v;
			5'h0a: f = c | !v;
			5'h0b: f = !c | v;
			5'h0c: f = !c | !v;
			5'h0d: f = c ^ v;
			5'h0e: f = c ^ !v;
			5'h0f: f = !c ^ v;
			5'h10: f = !c ^ !v;
			default: f = 1'b0;
		endcase
	endfunction

	always @(posedge sys_clk) begin
		rd_d <= bus_req.rd & sys_ce & ~sys_rst;
		if (evt_q === 1'b1) evt_seen++;
		if (rd_d || peek) begin
			nxt = exp_q.pop_front();
			if (rd_d) `CHK(rd_data_q, nxt)
			else `CHK({13'h0, ind_q, diag_label_q}, nxt)
		end
	end

	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(e);
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
	endtask

	// Settle, book any rise as an event, then look at the indicators and status
	task automatic stage(input logic [4:0] m, input logic c, input logic v);
		logic r;
		repeat (5) @(posedge sys_clk);
		r = f(m, c, v);
		if (r && !cur_r) begin
			rises++;
			evrec = {1'b1, 21'h0, v, c, 3'h0, m};
		end
		cur_r = r;
		cur_m = m;
		cur_c = c;
		cur_v = v;
		@(posedge sys_clk);
		peek <= 1'b1;
		exp_q.push_back({13'h0, r, r, r, r ? (cur_s ? label : UIA_DEFAULT_LABEL) : 16'h0});
		@(posedge sys_clk);
		peek <= 1'b0;
		rd(UIA_OFF_STATUS, {29'h0, v, c, r});
	endtask

	// One operand changes at a time, so every intermediate level is checked too
	task automatic apply(input logic [4:0] m, input logic c, input logic v, input logic s);
		label = 16'($urandom);
		cur_s = s;
		wr(UIA_OFF_LABEL, {16'h0, label});
		wr(UIA_OFF_CTRL, {23'h0, s, 3'h0, cur_m});
		want_closed <= c;
		stage(cur_m, c, cur_v);
		wr(UIA_OFF_VIRT, {31'h0, v});
		stage(cur_m, cur_c, v);
		wr(UIA_OFF_CTRL, {23'h0, s, 3'h0, m});
		stage(m, cur_c, cur_v);
	endtask

	initial begin
		void'($urandom(32'h438d));
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int a = 0; a <= 8'h18; a += 4) rd(8'(a), 32'h0);
		for (int m = 0; m <= 16; m++)
			for (int k = 0; k < 4; k++) apply(5'(m), k[1], k[0], 1'($urandom));
		repeat (20) apply(5'($urandom_range(16)), 1'($urandom), 1'($urandom), 1'($urandom));
		wr(UIA_OFF_CTRL, 32'h0000_001f);
		cur_s = 1'b0;
		stage(5'h0, cur_c, cur_v);
		rd(UIA_OFF_CTRL, 32'h0);
		sys_ce <= 1'b0;
		wr(UIA_OFF_CTRL, 32'h0000_0001);
		sys_ce <= 1'b1;
		rd(UIA_OFF_CTRL, 32'h0);
		rd(UIA_OFF_EVCNT, {16'h0, 16'(rises)});
		rd(UIA_OFF_EVREC, evrec);
		wr(UIA_OFF_EVREC, 32'h0);
		rd(UIA_OFF_EVREC, {1'b0, evrec[30:0]});
		repeat (4) @(posedge sys_clk);
		`CHK(evt_seen, rises)
		test_done;
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		failures++;
		test_done;
	end
endmodule
